// ===== rtl/sts_supervisor.sv
// safety timing supervisor: wake-up timer, watchdog, clock monitor, register port
// Summary of operation
// - wake-up timer may run on a 1 kHz tick divided from the bus clock by RC_DIV
// - period code 0 disables; codes 1-7 give 8 ms..1.024 s or divide 256..32768
// - cpu clock from internal rc or external, optionally through the multiplier
// - watchdog counts bus cycles, timeout 2^18 or 2^13 cycles
// - software must refresh in time, else an internal reset is raised
// - internal reset puts all pads in high impedance / safe state
// - external clock is monitored while the detect-disable bit is 0
// - with clock-loss reset enabled, clock below 500 or 25 kHz forces reset
// - in locked modes a too fast input clock sets the lock-lost flag
// - lock loss forces reset when lock-loss reset enable is set
// - timestamp counter runs at the bus clock divided by 1, 2, 4 or 8 for frequency checks
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sts_defines.svh"
module sts_supervisor #(
  parameter int RC_DIV     = `STS_RC_DIV,
  parameter int WDOG_LONG  = 1 << `STS_WDOG_LONG_LOG2,
  parameter int WDOG_SHORT = 1 << `STS_WDOG_SHORT_LOG2,
  parameter int IO_W       = 8
) (
  input  wire logic            mclk_i,
  input  wire logic            arst_n_i,
  input  wire logic [7:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  input  wire logic            ext_clk_i,
  input  wire logic [IO_W-1:0] gpio_out_i,
  input  wire logic [IO_W-1:0] gpio_oe_i,
  output logic      [IO_W-1:0] pad_out_o,
  output logic      [IO_W-1:0] pad_oe_o,
  output logic      [1:0]      clk_mode_o,
  output logic                 sys_rst_o,
  output logic                 io_safe_o,
  output logic                 irq_o
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  localparam int WDOG_W = $clog2(WDOG_LONG);
  localparam int RC_W   = (RC_DIV > 2) ? $clog2(RC_DIV) : 2;
  if (WDOG_SHORT < 2 || WDOG_SHORT > WDOG_LONG || RC_DIV < 2 || IO_W < 1) begin : g_bad_param
    $error("sts_supervisor: unsupported parameter values");
  end

  localparam logic [8:0] LOC_HI = 9'(`STS_LOC_HI_CYC);
  localparam logic [8:0] LOC_LO = 9'(`STS_LOC_LO_CYC);
  localparam logic [8:0] FAST   = 9'(`STS_FAST_CYC);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [3:0]        ctrl1_ff;
  logic              lock_lost_ff;
  logic [1:0]        ctrl2_ff;
  logic [3:0]        wake_ff;
  logic [1:0]        wdog_ff;
  logic [3:0]        stat_ff;
  logic [3:0]        mask_ff;
  logic [1:0]        ts_ctrl_ff;
  logic [15:0]       ts_cnt_ff;
  logic [7:0]        ts_hi_ff;
  logic [7:0]        ts_div_ff;
  logic [WDOG_W-1:0] wdog_cnt_ff;
  logic [RC_W-1:0]   rc_cnt_ff;
  logic              ext_d_ff;
  logic              seen_ff;
  logic [8:0]        gap_ff;
  logic [7:0]        rst_cnt_ff;
  logic [7:0]        rdata_ff;
  logic [IO_W-1:0]   pad_out_ff;
  logic [IO_W-1:0]   pad_oe_ff;

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ra, input logic w);
    return w && (a == ra);
  endfunction

  wire logic int_rst = (rst_cnt_ff != 8'h00);
  wire logic wr_ok   = wr_i && !int_rst;
  wire logic wr_c1   = wr_hit(addr_i, `STS_A_CTRL1, wr_ok);
  wire logic wr_c2   = wr_hit(addr_i, `STS_A_CTRL2, wr_ok);
  wire logic wr_wk   = wr_hit(addr_i, `STS_A_WAKE, wr_ok);
  wire logic wr_wd   = wr_hit(addr_i, `STS_A_WDOG, wr_ok);
  wire logic refresh = wr_hit(addr_i, `STS_A_REFRESH, wr_ok);
  wire logic wr_st   = wr_hit(addr_i, `STS_A_STAT, wr_ok);
  wire logic wr_mk   = wr_hit(addr_i, `STS_A_MASK, wr_ok);
  wire logic wr_tc   = wr_hit(addr_i, `STS_A_TS_CTRL, wr_ok);
  wire logic rd_tlo  = rd_i && (addr_i == `STS_A_TS_LO);

  // ****************************************************************
  // clock source mode
  // ****************************************************************
  sts_pkg::sts_clk_mode_t mode;
  wire logic ext_src = ctrl1_ff[`STS_C1_EXT_SRC];
  wire logic fll_en  = ctrl1_ff[`STS_C1_FLL_EN];
  assign mode = fll_en ? (ext_src ? sts_pkg::STS_MODE_FLL_EXT : sts_pkg::STS_MODE_FLL_INT) :
                         (ext_src ? sts_pkg::STS_MODE_EXT : sts_pkg::STS_MODE_INT_RC);
  wire logic locked_mode = (mode == sts_pkg::STS_MODE_FLL_EXT) || (mode == sts_pkg::STS_MODE_FLL_INT);

  // ****************************************************************
  // external clock monitor
  // ****************************************************************
  wire logic       ext_rise = ext_clk_i && !ext_d_ff;
  wire logic       loc_on   = !ctrl1_ff[`STS_C1_LOC_DIS];
  wire logic [8:0] loc_lim  = ctrl1_ff[`STS_C1_RANGE] ? LOC_LO : LOC_HI;
  wire logic       loc_evt  = loc_on && !ext_rise && (gap_ff == loc_lim);
  wire logic       lol_evt  = locked_mode && ext_rise && seen_ff && (gap_ff + 9'h001 < FAST);
  wire logic [8:0] nxt_gap  = ext_rise ? 9'h000 : (gap_ff > loc_lim) ? gap_ff : gap_ff + 9'h001;

  // ****************************************************************
  // watchdog
  // ****************************************************************
  wire logic [WDOG_W-1:0] wdog_lim = wdog_ff[`STS_WD_SHORT] ? WDOG_W'(WDOG_SHORT - 1)
                                                            : WDOG_W'(WDOG_LONG - 1);
  wire logic wdog_to = wdog_ff[`STS_WD_EN] && !int_rst && !refresh && (wdog_cnt_ff >= wdog_lim);
  wire logic [WDOG_W-1:0] nxt_wdog_cnt = (refresh || int_rst || !wdog_ff[`STS_WD_EN]) ? '0 :
                                         wdog_cnt_ff + WDOG_W'(1);

  // ****************************************************************
  // internal reset request
  // ****************************************************************
  wire logic rst_trig = wdog_to
                     || (loc_evt && ctrl2_ff[`STS_C2_CLOCK_LOSS_RESET_ENABLE])
                     || (lol_evt && ctrl2_ff[`STS_C2_LOCK_LOSS_RESET_ENABLE]);
  wire logic [7:0] nxt_rst_cnt = (rst_trig && !int_rst) ? `STS_RST_HOLD :
                                 int_rst ? rst_cnt_ff - 8'h01 : 8'h00;

  // ****************************************************************
  // wake-up timer and tick divider
  // ****************************************************************
  sts_wake_if wk ();
  wire logic rc_tick = (rc_cnt_ff == RC_W'(RC_DIV - 1));
  assign wk.rc_tick    = rc_tick;
  assign wk.ext_tick   = ext_rise;
  assign wk.src_ext    = wake_ff[`STS_WK_EXT];
  assign wk.period_sel = wake_ff[2:0];
  assign wk.restart    = wr_wk || int_rst;

  sts_wakeup_timer u_wake (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .wk       (wk)
  );

  // ****************************************************************
  // status, interrupt, timestamp
  // ****************************************************************
  wire logic [3:0] st_set = {wdog_to, lol_evt, loc_evt, wk.wake};
  wire logic [3:0] st_clr = wr_st ? wdata_i[3:0] : 4'h0;
  wire logic [3:0] nxt_stat = (stat_ff & ~st_clr) | st_set;   // set wins over clear
  wire logic nxt_lock_lost = lol_evt || (lock_lost_ff && !(wr_c1 && wdata_i[`STS_C1_LOCK_LOST]));
  wire logic [7:0] ts_step = (8'h01 << ts_ctrl_ff) - 8'h01;
  wire logic ts_inc = (ts_div_ff >= ts_step);

  // read mux
  wire logic [7:0] rd_mux =
    (addr_i == `STS_A_CTRL1)   ? {lock_lost_ff, 3'h0, ctrl1_ff} :
    (addr_i == `STS_A_CTRL2)   ? {6'h00, ctrl2_ff} :
    (addr_i == `STS_A_WAKE)    ? {4'h0, wake_ff} :
    (addr_i == `STS_A_WDOG)    ? {6'h00, wdog_ff} :
    (addr_i == `STS_A_STAT)    ? {4'h0, stat_ff} :
    (addr_i == `STS_A_MASK)    ? {4'h0, mask_ff} :
    (addr_i == `STS_A_TS_LO)   ? ts_cnt_ff[7:0] :
    (addr_i == `STS_A_TS_HI)   ? ts_hi_ff :
    (addr_i == `STS_A_TS_CTRL) ? {6'h00, ts_ctrl_ff} : 8'h00;

  assign rdata_o    = rdata_ff;
  assign irq_o      = |(stat_ff & mask_ff);
  assign sys_rst_o  = int_rst;
  assign io_safe_o  = int_rst;
  assign pad_out_o  = pad_out_ff;
  assign pad_oe_o   = pad_oe_ff;
  assign clk_mode_o = mode;

  // control registers, returned to their reset values by the internal reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl1_ff   <= `STS_RST_CTRL1;
      ctrl2_ff   <= `STS_RST_CTRL2;
      wake_ff    <= `STS_RST_WAKE;
      wdog_ff    <= `STS_RST_WDOG;
      ts_ctrl_ff <= `STS_RST_TS;
      mask_ff    <= 4'h0;
    end else if (int_rst) begin
      ctrl1_ff   <= `STS_RST_CTRL1;
      ctrl2_ff   <= `STS_RST_CTRL2;
      wake_ff    <= `STS_RST_WAKE;
      wdog_ff    <= `STS_RST_WDOG;
      ts_ctrl_ff <= `STS_RST_TS;
      mask_ff    <= 4'h0;
    end else begin
      if (wr_c1) ctrl1_ff <= wdata_i[3:0];
      if (wr_c2) ctrl2_ff <= wdata_i[1:0];
      if (wr_wk) wake_ff <= wdata_i[3:0];
      if (wr_wd) wdog_ff <= wdata_i[1:0];
      if (wr_tc) ts_ctrl_ff <= wdata_i[1:0];
      if (wr_mk) mask_ff <= wdata_i[3:0];
    end
  end

  // flags, counters and read data
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_ff      <= 4'h0;
      lock_lost_ff <= 1'b0;
      wdog_cnt_ff  <= '0;
      rc_cnt_ff    <= '0;
      ext_d_ff     <= 1'b0;
      seen_ff      <= 1'b0;
      gap_ff       <= 9'h000;
      rst_cnt_ff   <= 8'h00;
      rdata_ff     <= 8'h00;
    end else begin
      stat_ff      <= nxt_stat;
      lock_lost_ff <= nxt_lock_lost;
      wdog_cnt_ff  <= nxt_wdog_cnt;
      rc_cnt_ff    <= rc_tick ? '0 : rc_cnt_ff + RC_W'(1);
      ext_d_ff     <= ext_clk_i;
      seen_ff      <= seen_ff || ext_rise;
      gap_ff       <= nxt_gap;
      rst_cnt_ff   <= nxt_rst_cnt;
      rdata_ff     <= rd_i ? rd_mux : 8'h00;
    end
  end

  // timestamp counter at bus clock divided by 1, 2, 4 or 8
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ts_cnt_ff <= 16'h0000;
      ts_div_ff <= 8'h00;
      ts_hi_ff  <= 8'h00;
    end else begin
      ts_div_ff <= ts_inc ? 8'h00 : ts_div_ff + 8'h01;
      if (ts_inc) ts_cnt_ff <= ts_cnt_ff + 16'h0001;
      if (rd_tlo) ts_hi_ff <= ts_cnt_ff[15:8];       // high byte frozen by low read
    end
  end

  // pads forced off during the internal reset
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pad_out_ff <= '0;
      pad_oe_ff  <= '0;
    end else begin
      pad_out_ff <= int_rst ? '0 : gpio_out_i;
      pad_oe_ff  <= int_rst ? '0 : gpio_oe_i;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_wdog_timeout_rst: assert property (wdog_ff[`STS_WD_EN] && !int_rst && !refresh && wdog_cnt_ff == wdog_lim
    |=> sys_rst_o && stat_ff[`STS_ST_WDOG]) else $error("watchdog timeout without reset");
  a_refresh_restart: assert property (refresh && !int_rst && wdog_ff[`STS_WD_EN] |=> wdog_cnt_ff == '0)
    else $error("refresh did not restart count");
  a_rst_hold: assert property ($rose(sys_rst_o) |-> sys_rst_o [*8]) else $error("reset too short");
  a_pads_safe: assert property (sys_rst_o |=> pad_oe_o == '0 && pad_out_o == '0) else $error("pads driven in reset");
  a_loc_disabled: assert property (ctrl1_ff[`STS_C1_LOC_DIS] |-> !loc_evt) else $error("loss seen while disabled");
  a_loc_gap: assert property (loc_on && gap_ff == loc_lim && !ext_rise |=> stat_ff[`STS_ST_LOC])
    else $error("clock loss not flagged");
  a_loc_reset: assert property (loc_evt && ctrl2_ff[`STS_C2_CLOCK_LOSS_RESET_ENABLE] |=> sys_rst_o) else $error("no reset on clock loss");
  a_lol_flag: assert property (lol_evt |=> lock_lost_ff && stat_ff[`STS_ST_LOL]) else $error("lock loss not flagged");
  a_lol_reset: assert property (lol_evt && ctrl2_ff[`STS_C2_LOCK_LOSS_RESET_ENABLE] |=> sys_rst_o) else $error("no reset on lock loss");
  a_ts_runs: assert property (ts_ctrl_ff == 2'h0 && !int_rst && !wr_tc |=> ts_cnt_ff == $past(ts_cnt_ff) + 16'h0001)
    else $error("timestamp not counting bus cycles");
  a_irq_wake: assert property (wk.wake && mask_ff[`STS_ST_WAKE] && !int_rst |=> irq_o) else $error("wake irq missing");
  a_rd_unmapped: assert property (rd_i && addr_i > `STS_A_TS_CTRL |=> rdata_o == 8'h00) else $error("unmapped read nonzero");

  c_wdog_reset: cover property (wdog_to ##1 sys_rst_o);
  c_lock_lost: cover property (lol_evt ##1 lock_lost_ff);
  c_clock_loss: cover property (loc_evt && ctrl2_ff[`STS_C2_CLOCK_LOSS_RESET_ENABLE]);
  c_wake_irq: cover property (wk.wake ##1 irq_o);
endmodule
`default_nettype wire

// ===== rtl/sts_defines.svh
// constants of the safety timing supervisor: addresses, fields, reset values, timing
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define STS_CLK_HZ          10000000
`define STS_RC_HZ           1000
`define STS_RC_DIV          (`STS_CLK_HZ / `STS_RC_HZ)
`define STS_LOC_HI_HZ       500000
`define STS_LOC_LO_HZ       25000
`define STS_LOC_HI_CYC      (`STS_CLK_HZ / `STS_LOC_HI_HZ)
`define STS_LOC_LO_CYC      (`STS_CLK_HZ / `STS_LOC_LO_HZ)
`define STS_FAST_CYC        3
`define STS_WDOG_LONG_LOG2  18
`define STS_WDOG_SHORT_LOG2 13
`define STS_RST_HOLD        8'h10

// ****************************************************************
// wake-up periods in source ticks, codes 1 to 7
// ****************************************************************
`define STS_WAKE_RC_1  16'h0008
`define STS_WAKE_RC_2  16'h0020
`define STS_WAKE_RC_3  16'h0040
`define STS_WAKE_RC_4  16'h0080
`define STS_WAKE_RC_5  16'h0100
`define STS_WAKE_RC_6  16'h0200
`define STS_WAKE_RC_7  16'h0400
`define STS_WAKE_EX_1  16'h0100
`define STS_WAKE_EX_2  16'h0400
`define STS_WAKE_EX_3  16'h0800
`define STS_WAKE_EX_4  16'h1000
`define STS_WAKE_EX_5  16'h2000
`define STS_WAKE_EX_6  16'h4000
`define STS_WAKE_EX_7  16'h8000

// ****************************************************************
// register addresses
// ****************************************************************
`define STS_A_CTRL1    8'h00
`define STS_A_CTRL2    8'h01
`define STS_A_WAKE     8'h02
`define STS_A_WDOG     8'h03
`define STS_A_REFRESH  8'h04
`define STS_A_STAT     8'h05
`define STS_A_MASK     8'h06
`define STS_A_TS_LO    8'h07
`define STS_A_TS_HI    8'h08
`define STS_A_TS_CTRL  8'h09

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define STS_C1_LOC_DIS 0
`define STS_C1_EXT_SRC 1
`define STS_C1_FLL_EN  2
`define STS_C1_RANGE   3
`define STS_C1_LOCK_LOST 7
`define STS_C2_CLOCK_LOSS_RESET_ENABLE   0
`define STS_C2_LOCK_LOSS_RESET_ENABLE   1
`define STS_WK_EXT     3
`define STS_WD_EN      0
`define STS_WD_SHORT   1
`define STS_ST_WAKE    0
`define STS_ST_LOC     1
`define STS_ST_LOL     2
`define STS_ST_WDOG    3
`define STS_RST_CTRL1  4'h0
`define STS_RST_CTRL2  2'h0
`define STS_RST_WAKE   4'h0
`define STS_RST_WDOG   2'h1
`define STS_RST_TS     2'h0

`endif

// ===== rtl/sts_pkg.sv
// types of the safety timing supervisor
package sts_pkg;
  // cpu clock source and multiplier mode
  typedef enum logic [1:0] {
    STS_MODE_INT_RC,
    STS_MODE_EXT,
    STS_MODE_FLL_INT,
    STS_MODE_FLL_EXT
  } sts_clk_mode_t;
endpackage

// ===== rtl/sts_wake_if.sv
// link between the supervisor core and its wake-up timer
`timescale 1ns/1ps
`default_nettype none
interface sts_wake_if;
  logic       rc_tick;
  logic       ext_tick;
  logic       src_ext;
  logic [2:0] period_sel;
  logic       restart;
  logic       wake;
  modport ctl (output rc_tick, output ext_tick, output src_ext, output period_sel, output restart, input wake);
  modport tmr (input rc_tick, input ext_tick, input src_ext, input period_sel, input restart, output wake);
endinterface
`default_nettype wire

// ===== rtl/sts_wakeup_timer.sv
// periodic wake-up timer counting rc or external clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "sts_defines.svh"
module sts_wakeup_timer (
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  sts_wake_if.tmr   wk
);

  // ****************************************************************
  // period table
  // ****************************************************************
  function automatic logic [15:0] period_of(input logic [2:0] sel, input logic ext);
    logic [15:0] p;
    p = 16'h0001;
    case (sel)
      3'h1: p = ext ? `STS_WAKE_EX_1 : `STS_WAKE_RC_1;
      3'h2: p = ext ? `STS_WAKE_EX_2 : `STS_WAKE_RC_2;
      3'h3: p = ext ? `STS_WAKE_EX_3 : `STS_WAKE_RC_3;
      3'h4: p = ext ? `STS_WAKE_EX_4 : `STS_WAKE_RC_4;
      3'h5: p = ext ? `STS_WAKE_EX_5 : `STS_WAKE_RC_5;
      3'h6: p = ext ? `STS_WAKE_EX_6 : `STS_WAKE_RC_6;
      3'h7: p = ext ? `STS_WAKE_EX_7 : `STS_WAKE_RC_7;
      default: p = 16'h0001;
    endcase
    return p;
  endfunction

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        wake_ff;
  wire  logic        tick;
  wire  logic [15:0] last;
  wire  logic        hit;

  // source choice and terminal compare
  assign tick = wk.src_ext ? wk.ext_tick : wk.rc_tick;
  assign last = period_of(wk.period_sel, wk.src_ext) - 16'h0001;
  assign hit  = tick && (cnt_ff == last) && (wk.period_sel != 3'h0) && !wk.restart;
  assign nxt_cnt = (wk.restart || wk.period_sel == 3'h0) ? 16'h0000 :
                   hit ? 16'h0000 : tick ? cnt_ff + 16'h0001 : cnt_ff;
  assign wk.wake = wake_ff;

  // tick counter and wake pulse
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff  <= 16'h0000;
      wake_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      wake_ff <= hit;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_wake_off_code: assert property (wk.period_sel == 3'h0 |=> !wk.wake) else $error("wake while disabled");
  a_wake_on_term: assert property (tick && cnt_ff == last && wk.period_sel != 3'h0 && !wk.restart
    |=> wk.wake && cnt_ff == 16'h0000) else $error("wake not at period end");
  c_wake_rc: cover property (wk.wake && !wk.src_ext);
endmodule
`default_nettype wire

// ===== test/sts_ext_clk_model.sv
// model of the external clock source feeding the clock monitor
`timescale 1ns/1ps
`default_nettype none
module sts_ext_clk_model (
  input  wire logic       mclk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            ext_clk_o
);
  logic [7:0] cnt_ff;
  // toggle every half_i cycles; a stopped source rests low, as a dead crystal
  always_ff @(posedge mclk_i) begin
    if (!run_i) begin
      cnt_ff    <= 8'h00;
      ext_clk_o <= 1'b0;
    end else if (cnt_ff >= half_i - 8'h01) begin
      cnt_ff    <= 8'h00;
      ext_clk_o <= ~ext_clk_o;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking testbench of the safety timing supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sts_defines.svh"
module tb;
  logic       mclk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] gpio_out_i = 8'hA5;
  logic [7:0] gpio_oe_i = 8'hFF;
  logic [7:0] half = 8'h05;
  logic       run = 1'b0;
  logic [7:0] rdata_o, pad_out_o, pad_oe_o, v, w;
  logic [1:0] clk_mode_o;
  logic       sys_rst_o, io_safe_o, irq_o, ext_clk;
  int         err_total = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  // ************************************************
  // design, far-side clock, clock and timeout
  // ************************************************
  sts_supervisor #(.RC_DIV(10), .WDOG_LONG(64), .WDOG_SHORT(16), .IO_W(8)) u_sts_supervisor (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_i(ext_clk), .gpio_out_i(gpio_out_i),
    .gpio_oe_i(gpio_oe_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .clk_mode_o(clk_mode_o),
    .sys_rst_o(sys_rst_o), .io_safe_o(io_safe_o), .irq_o(irq_o));
  sts_ext_clk_model u_sts_ext_clk_model (.mclk_i(mclk_i), .run_i(run), .half_i(half), .ext_clk_o(ext_clk));
  // 100 ns period
  always #50 mclk_i = ~mclk_i;
  // cut a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  // ************************************************
  // bus and check tasks
  // ************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // wait for an internal reset, check the pads, wait until it ends
  task automatic wait_rst(input int lim);
    int n;
    n = 0;
    while (sys_rst_o !== 1'b1 && n < lim) begin
      idle(1);
      n++;
    end
    chk("sys_rst_o", 8'h01, {7'h00, sys_rst_o});
    idle(1);
    chk("pad_oe_o", 8'h00, pad_oe_o);
    chk("io_safe_o", 8'h01, {7'h00, io_safe_o});
    n = 0;
    while (sys_rst_o !== 1'b0 && n < 40) begin
      idle(1);
      n++;
    end
    idle(2);
    chk("pad_out_o", 8'hA5, pad_out_o);
    chk("pad_oe_o back", 8'hFF, pad_oe_o);
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_watchdog();
    rd(`STS_A_WDOG, v);
    chk("wdog reset", 8'h01, v);
    idle(1);
    chk("rdata stands one cycle", 8'h00, rdata_o);
    rd(8'hFF, v);
    chk("unmapped", 8'h00, v);
    repeat (4) begin
      wr(`STS_A_REFRESH, 8'h00);
      idle(50);
    end
    wr(`STS_A_REFRESH, 8'h00);
    idle(55);
    chk("no early reset", 8'h00, {7'h00, sys_rst_o});
    wait_rst(20);
    rd(`STS_A_STAT, v);
    chk("wdog cause", 8'h08, v & 8'h08);
    wr(`STS_A_WDOG, 8'h00);
    wr(`STS_A_MASK, 8'h08);
    chk("irq set", 8'h01, {7'h00, irq_o});
    wr(`STS_A_MASK, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq_o});
    wr(`STS_A_STAT, 8'h08);
    wr(`STS_A_MASK, 8'h08);
    chk("irq cleared", 8'h00, {7'h00, irq_o});
    wr(`STS_A_WDOG, 8'h03);
    wr(`STS_A_REFRESH, 8'h00);
    idle(12);
    chk("short early", 8'h00, {7'h00, sys_rst_o});
    wait_rst(10);
    wr(`STS_A_WDOG, 8'h00);
    $display("test watchdog done");
  endtask
  task automatic t_clock_mon();
    run <= 1'b1;
    wr(`STS_A_CTRL2, 8'h01);
    idle(40);
    chk("clock present", 8'h00, {7'h00, sys_rst_o});
    run <= 1'b0;
    wait_rst(40);
    rd(`STS_A_STAT, v);
    chk("loss cause", 8'h02, v & 8'h02);
    wr(`STS_A_WDOG, 8'h00);
    wr(`STS_A_CTRL1, 8'h01);
    wr(`STS_A_STAT, 8'h0F);
    wr(`STS_A_CTRL2, 8'h01);
    run <= 1'b1;
    idle(40);
    run <= 1'b0;
    idle(60);
    rd(`STS_A_STAT, v);
    chk("detect off", 8'h00, (v & 8'h02) | {7'h00, sys_rst_o});
    wr(`STS_A_CTRL1, 8'h06);
    chk("clk mode", 8'h03, {6'h00, clk_mode_o});
    wr(`STS_A_CTRL2, 8'h02);
    half <= 8'h01;
    run <= 1'b1;
    wait_rst(20);
    run <= 1'b0;
    rd(`STS_A_CTRL1, v);
    chk("lock lost", 8'h80, v & 8'h80);
    chk("mode reset", 8'h00, {6'h00, clk_mode_o});
    wr(`STS_A_WDOG, 8'h00);
    $display("test clock monitor done");
  endtask
  task automatic t_wake_ts();
    int p;
    wr(`STS_A_WAKE, 8'h00);
    wr(`STS_A_STAT, 8'h0F);
    idle(120);
    rd(`STS_A_STAT, v);
    chk("wake off", 8'h00, v & 8'h01);
    for (int c = 1; c < 8; c++) begin
      p = (c == 1) ? 80 : (160 << (c - 1));
      wr(`STS_A_WAKE, c[7:0]);
      wr(`STS_A_STAT, 8'h0F);
      idle(p - 20);
      rd(`STS_A_STAT, v);
      chk("wake early", 8'h00, v & 8'h01);
      idle(25);
      rd(`STS_A_STAT, v);
      chk("wake due", 8'h01, v & 8'h01);
    end
    wr(`STS_A_TS_CTRL, 8'h00);
    rd(`STS_A_TS_LO, v);
    idle(20);
    rd(`STS_A_TS_LO, w);
    chk("stamp step", 8'h16, w - v);
    $display("test wake and stamp done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_watchdog();
    t_clock_mon();
    t_wake_ts();
    final_report();
  end
endmodule
`default_nettype wire
